// file: core/atacpe_pkg.sv
// package of constants for the ata command protocol engine
package atacpe_pkg;
  // task file register addresses (3-bit host port address)
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_ERROR_FEATURES = 3'h1;
  localparam logic [2:0] ADDR_SECCOUNT = 3'h2;
  localparam logic [2:0] ADDR_SECNUM = 3'h3;
  localparam logic [2:0] ADDR_CYL_LOW = 3'h4;
  localparam logic [2:0] ADDR_CYL_HIGH = 3'h5;
  localparam logic [2:0] ADDR_DEVHEAD = 3'h6;
  localparam logic [2:0] ADDR_STATUS_COMMAND = 3'h7;
  // status bit positions
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  // error register bit positions
  localparam int ER_UNC = 6;
  localparam int ER_ABRT = 2;
  // reset values and crc polynomial
  localparam logic [7:0] RST_ERROR = 8'h01;
  localparam logic [7:0] RST_SECCOUNT = 8'h01;
  localparam logic [7:0] RST_SECNUM = 8'h01;
  localparam logic [7:0] RST_MULTIPLE = 8'h10;
  localparam logic [15:0] CRC_INIT = 16'h4aba;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // transfer mode encodings as taken from set-features
  localparam logic [1:0] XFER_MWDMA = 2'h0;
  localparam logic [1:0] XFER_UDMA = 2'h1;
  localparam logic [2:0] RST_DMA_MODE = 3'h2;
  // command classes supplied by the command decoder
  typedef enum logic [2:0] {
    CLS_NONDATA = 3'h0,
    CLS_PIO_IN = 3'h1,
    CLS_PIO_OUT = 3'h2,
    CLS_DMA_IN = 3'h3,
    CLS_DMA_OUT = 3'h4,
    CLS_INVALID = 3'h5
  } atacpe_class_t;
  // sequencer states, gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BUSY = 3'b001,
    ST_XFER = 3'b011,
    ST_POST = 3'b010,
    ST_DMA = 3'b110
  } atacpe_state_t;
endpackage

// file: core/atacpe_engine.sv
// ata command protocol sequencer, device side
// Operation
// - status read, reset or command write clear interrupt; alternate status does not
// - pio read sets busy per unit, then data request, busy clear, interrupt
// - host reads status after interrupt; device drops interrupt on that read
// - data request clears once the whole pio read unit has moved
// - multiple commands move a block per interrupt, others one sector
// - invalid parameter ends command with error, abort bit and interrupt
// - uncorrectable read error: data request, error, failing address, interrupt
// - defective sector data still supplied and host finishes the unit
// - pio write sets busy, then data request with busy clear when ready
// - write unit arrived: busy; processed: busy clear, interrupt, data request unless it was the last unit
// - unrecoverable write error: data request, error, failing address, interrupt
// - non-data sets busy, then clears busy and interrupts, dropped on status read
// - dma command sets busy then raises dma request when ready
// - dma commands interrupt exactly once at the end of all data
// - dma mode defaults to multiword mode 2 until set-features selects a transfer mode
// - ultra burst spans acknowledge assertion to negation with three phases
// - receiver accepts at least two data words
// - crc compared at each burst end; a burst ends on every sector
// - crc starts at 4aba with polynomial x16+x12+x5+1 per strobe word
// - host stop is acknowledged by dropping dma request, and the reverse
`timescale 1ns/100ps
`default_nettype none
module atacpe_engine #(
  parameter int WORDS_PER_SECTOR = 256
) (
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  input wire logic SOFT_RESET_IN,
  input wire logic [2:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WRITE_IN,
  input wire logic READ_IN,
  input wire logic ALT_READ_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic DATA_WORD_IN,
  input wire logic [2:0] CMD_CLASS_IN,
  input wire logic CMD_MULTIPLE_IN,
  input wire logic PARAM_BAD_IN,
  input wire logic UNIT_READY_IN,
  input wire logic MEDIA_ERROR_IN,
  input wire logic MEDIA_UNC_IN,
  input wire logic [7:0] FAIL_SECNUM_IN,
  input wire logic [15:0] FAIL_CYL_IN,
  input wire logic [3:0] FAIL_HEAD_IN,
  input wire logic SET_MULTIPLE_IN,
  input wire logic SET_XFER_IN,
  input wire logic [1:0] SET_XFER_KIND_IN,
  input wire logic [2:0] SET_XFER_MODE_IN,
  input wire logic DMACK_N_IN,
  input wire logic STOP_IN,
  input wire logic STROBE_WORD_IN,
  input wire logic [15:0] DD_IN,
  input wire logic DEV_END_BURST_IN,
  output logic INTRQ_OUT,
  output logic DMARQ_OUT,
  output logic [7:0] STATUS_OUT,
  output logic [7:0] COMMAND_OUT,
  output logic COMMAND_STROBE_OUT,
  output logic UDMA_ON_OUT,
  output logic [2:0] DMA_MODE_OUT,
  output logic CRC_ERROR_OUT
);
  // crc step over one 16-bit word, lsb-first serial equivalent
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 16; i++) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ atacpe_pkg::CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  atacpe_pkg::atacpe_state_t state_q, state_d;
  logic [7:0] err_q, feat_q, count_q, secnum_q, cyl_lo_q, cyl_hi_q, devhead_q, cmd_q;
  logic [7:0] status_q, multiple_q;
  logic [2:0] class_q;
  logic mult_q, intrq_q, dmarq_q, udma_q, crc_err_q, cmd_stb_q, burst_q;
  logic [2:0] dma_mode_q;
  logic [15:0] crc_q, words_q, unit_words_q;
  logic [7:0] rdata_q;

  wire any_reset = RESET_IN | SOFT_RESET_IN;
  wire cmd_write = WRITE_IN & (ADDR_IN == atacpe_pkg::ADDR_STATUS_COMMAND);
  wire status_read = READ_IN & (ADDR_IN == atacpe_pkg::ADDR_STATUS_COMMAND);
  wire data_access = DATA_WORD_IN & status_q[atacpe_pkg::ST_DRQ];
  wire [15:0] unit_len = mult_q ? 16'(multiple_q) * 16'(WORDS_PER_SECTOR) : 16'(WORDS_PER_SECTOR);
  wire unit_done = data_access & (words_q == unit_len - 16'h0001);
  wire is_dma = (class_q == atacpe_pkg::CLS_DMA_IN) | (class_q == atacpe_pkg::CLS_DMA_OUT);
  wire is_in = (class_q == atacpe_pkg::CLS_PIO_IN);
  wire is_out = (class_q == atacpe_pkg::CLS_PIO_OUT);
  wire burst_start = dmarq_q & ~DMACK_N_IN & ~burst_q;
  wire burst_end = burst_q & DMACK_N_IN;
  // strobe edges are ignored once dma request drops or stop is raised
  wire strobe_ok = burst_q & dmarq_q & ~STOP_IN & STROBE_WORD_IN & ~DMACK_N_IN;
  wire dma_last_word = strobe_ok & (words_q == unit_len - 16'h0001);
  // sector count remaining is tracked in the count register
  wire [7:0] unit_secs = mult_q ? multiple_q : 8'h01;
  // a block read ends the command once no more than one unit is left
  wire last_unit = (count_q <= unit_secs);
  // after a written unit the count has already been decremented
  wire out_done = (count_q == 8'h00);
  wire [7:0] count_left = (count_q > unit_secs) ? count_q - unit_secs : 8'h00;

  logic [7:0] rd_mux;
  always_comb begin
    case (ADDR_IN)
      atacpe_pkg::ADDR_ERROR_FEATURES: rd_mux = err_q;
      atacpe_pkg::ADDR_SECCOUNT: rd_mux = count_q;
      atacpe_pkg::ADDR_SECNUM: rd_mux = secnum_q;
      atacpe_pkg::ADDR_CYL_LOW: rd_mux = cyl_lo_q;
      atacpe_pkg::ADDR_CYL_HIGH: rd_mux = cyl_hi_q;
      atacpe_pkg::ADDR_DEVHEAD: rd_mux = devhead_q;
      atacpe_pkg::ADDR_STATUS_COMMAND: rd_mux = status_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // next state of the command sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      atacpe_pkg::ST_IDLE: begin
        if (cmd_write) begin
          state_d = atacpe_pkg::ST_BUSY;
        end
      end
      atacpe_pkg::ST_BUSY: begin
        if (PARAM_BAD_IN) begin
          state_d = atacpe_pkg::ST_IDLE;
        end else if (UNIT_READY_IN | MEDIA_ERROR_IN) begin
          if (class_q == atacpe_pkg::CLS_NONDATA) begin
            state_d = atacpe_pkg::ST_IDLE;
          end else if (is_dma) begin
            state_d = atacpe_pkg::ST_DMA;
          end else begin
            state_d = atacpe_pkg::ST_XFER;
          end
        end
      end
      atacpe_pkg::ST_XFER: begin
        if (unit_done) begin
          if (is_out) begin
            state_d = atacpe_pkg::ST_POST;
          end else if (status_q[atacpe_pkg::ST_ERR] | last_unit) begin
            state_d = atacpe_pkg::ST_IDLE;
          end else begin
            state_d = atacpe_pkg::ST_BUSY;
          end
        end
      end
      atacpe_pkg::ST_POST: begin
        if (UNIT_READY_IN | MEDIA_ERROR_IN) begin
          if (MEDIA_ERROR_IN | out_done) begin
            state_d = atacpe_pkg::ST_IDLE;
          end else begin
            state_d = atacpe_pkg::ST_XFER;
          end
        end
      end
      atacpe_pkg::ST_DMA: begin
        if (burst_end && count_q == 8'h00) begin
          state_d = atacpe_pkg::ST_IDLE;
        end
      end
      default: state_d = atacpe_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (any_reset) begin
      state_q <= atacpe_pkg::ST_IDLE;
      words_q <= 16'h0000;
      burst_q <= 1'b0;
      dmarq_q <= 1'b0;
      crc_q <= atacpe_pkg::CRC_INIT;
    end else begin
      state_q <= state_d;
      // word count spans bursts so a sector may be split by early stops
      if (cmd_write || unit_done || dma_last_word) begin
        words_q <= 16'h0000;
      end else if (data_access || strobe_ok) begin
        words_q <= words_q + 16'h0001;
      end
      // dma request rises when ready and drops at each sector end, on stop or when the device ends the burst
      if (state_q == atacpe_pkg::ST_DMA && !burst_q && count_q != 8'h00 && DMACK_N_IN) begin
        dmarq_q <= 1'b1;
      end else if (dmarq_q && burst_q && (STOP_IN || dma_last_word || DEV_END_BURST_IN)) begin
        dmarq_q <= 1'b0;
      end
      if (burst_start) begin
        burst_q <= 1'b1;
        crc_q <= atacpe_pkg::CRC_INIT;
      end else if (burst_end) begin
        burst_q <= 1'b0;
      end else if (strobe_ok) begin
        crc_q <= crc_step(crc_q, DD_IN);
      end
    end
  end

  // task file, status and interrupt
  always_ff @(posedge CLOCK_IN) begin
    if (any_reset) begin
      err_q <= atacpe_pkg::RST_ERROR;
      feat_q <= 8'h00;
      count_q <= atacpe_pkg::RST_SECCOUNT;
      secnum_q <= atacpe_pkg::RST_SECNUM;
      cyl_lo_q <= 8'h00;
      cyl_hi_q <= 8'h00;
      devhead_q <= 8'h00;
      cmd_q <= 8'h00;
      class_q <= atacpe_pkg::CLS_NONDATA;
      mult_q <= 1'b0;
      status_q <= 8'h50;
      intrq_q <= 1'b0;
      crc_err_q <= 1'b0;
      cmd_stb_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      cmd_stb_q <= cmd_write;
      rdata_q <= READ_IN ? rd_mux : 8'h00;
      if (WRITE_IN && state_q == atacpe_pkg::ST_IDLE) begin
        case (ADDR_IN)
          atacpe_pkg::ADDR_ERROR_FEATURES: feat_q <= WDATA_IN;
          atacpe_pkg::ADDR_SECCOUNT: count_q <= WDATA_IN;
          atacpe_pkg::ADDR_SECNUM: secnum_q <= WDATA_IN;
          atacpe_pkg::ADDR_CYL_LOW: cyl_lo_q <= WDATA_IN;
          atacpe_pkg::ADDR_CYL_HIGH: cyl_hi_q <= WDATA_IN;
          atacpe_pkg::ADDR_DEVHEAD: devhead_q <= WDATA_IN;
          default: cmd_q <= cmd_q;
        endcase
      end
      // a new event wins over a same-cycle status read clear
      if (cmd_write) begin
        cmd_q <= WDATA_IN;
        class_q <= CMD_CLASS_IN;
        mult_q <= CMD_MULTIPLE_IN;
        err_q <= 8'h00;
        crc_err_q <= 1'b0;
        status_q <= 8'h80;
        intrq_q <= 1'b0;
      end else begin
        if (status_read && !ALT_READ_IN) begin
          intrq_q <= 1'b0;
        end
        case (state_q)
          atacpe_pkg::ST_BUSY: begin
            if (PARAM_BAD_IN) begin
              err_q[atacpe_pkg::ER_ABRT] <= 1'b1;
              status_q <= 8'h51;
              intrq_q <= 1'b1;
            end else if (UNIT_READY_IN || MEDIA_ERROR_IN) begin
              if (class_q == atacpe_pkg::CLS_NONDATA) begin
                status_q <= 8'h50;
                intrq_q <= 1'b1;
              end else if (is_dma) begin
                status_q <= 8'h80;
              end else if (MEDIA_ERROR_IN && is_in) begin
                status_q <= 8'h59;
                err_q[atacpe_pkg::ER_UNC] <= MEDIA_UNC_IN;
                secnum_q <= FAIL_SECNUM_IN;
                cyl_lo_q <= FAIL_CYL_IN[7:0];
                cyl_hi_q <= FAIL_CYL_IN[15:8];
                devhead_q <= {devhead_q[7:4], FAIL_HEAD_IN};
                intrq_q <= 1'b1;
              end else begin
                status_q <= 8'h58;
                intrq_q <= is_in;
              end
            end
          end
          atacpe_pkg::ST_XFER: begin
            if (unit_done) begin
              count_q <= count_left;
              if (is_out) begin
                status_q <= 8'h80;
              end else if (status_q[atacpe_pkg::ST_ERR] || last_unit) begin
                status_q <= {status_q[7:4], 1'b0, status_q[2:0]};
              end else begin
                status_q <= 8'h80;
              end
            end
          end
          atacpe_pkg::ST_POST: begin
            if (MEDIA_ERROR_IN) begin
              status_q <= 8'h59;
              err_q[atacpe_pkg::ER_UNC] <= MEDIA_UNC_IN;
              secnum_q <= FAIL_SECNUM_IN;
              cyl_lo_q <= FAIL_CYL_IN[7:0];
              cyl_hi_q <= FAIL_CYL_IN[15:8];
              devhead_q <= {devhead_q[7:4], FAIL_HEAD_IN};
              intrq_q <= 1'b1;
            end else if (UNIT_READY_IN) begin
              status_q <= out_done ? 8'h50 : 8'h58;
              intrq_q <= 1'b1;
            end
          end
          atacpe_pkg::ST_DMA: begin
            if (dma_last_word) begin
              count_q <= count_left;
            end
            if (burst_end) begin
              // the host drives its crc on the bus as acknowledge drops
              if (crc_q != DD_IN) begin
                crc_err_q <= 1'b1;
              end
              if (count_q == 8'h00) begin
                status_q <= (crc_err_q || crc_q != DD_IN) ? 8'h51 : 8'h50;
                intrq_q <= 1'b1;
              end
            end
          end
          default: status_q <= status_q;
        endcase
      end
    end
  end

  // transfer mode survives soft reset, defaults to multiword mode 2 on hard reset
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      multiple_q <= atacpe_pkg::RST_MULTIPLE;
      udma_q <= 1'b0;
      dma_mode_q <= atacpe_pkg::RST_DMA_MODE;
    end else begin
      if (SET_MULTIPLE_IN) begin
        multiple_q <= count_q;
      end
      if (SET_XFER_IN) begin
        udma_q <= (SET_XFER_KIND_IN == atacpe_pkg::XFER_UDMA);
        dma_mode_q <= SET_XFER_MODE_IN;
      end
    end
  end

  assign RDATA_OUT = rdata_q;
  assign INTRQ_OUT = intrq_q;
  assign DMARQ_OUT = dmarq_q;
  assign STATUS_OUT = status_q;
  assign COMMAND_OUT = cmd_q;
  assign COMMAND_STROBE_OUT = cmd_stb_q;
  assign UDMA_ON_OUT = udma_q;
  assign DMA_MODE_OUT = dma_mode_q;
  assign CRC_ERROR_OUT = crc_err_q;
endmodule // atacpe_engine
`default_nettype wire

// file: verification/atacpe_host_model.sv
// host dma channel model for the ata command protocol engine
`timescale 1ns/100ps
`default_nettype none
module atacpe_host_model #(
  parameter int WORDS = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic dmarq_in,
  input wire logic stop_early_in,
  input wire logic bad_crc_in,
  output logic dmack_n_out,
  output logic stop_out,
  output logic strobe_out,
  output logic [15:0] dd_out
);
  int pos;
  int n;
  logic [15:0] crc;
  logic [15:0] w;
  // bit 0 enters first, register shifts toward msb
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    logic fb;
    for (int i = 0; i < 16; i++) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction
  initial begin
    dmack_n_out = 1'b1;
    stop_out = 1'b0;
    strobe_out = 1'b0;
    dd_out = 16'h0000;
    pos = 0;
    forever begin
      @(negedge clk_in);
      if (rst_in) begin
        pos = 0;
      end else if (dmarq_in) begin
        @(posedge clk_in);
        dmack_n_out <= 1'b0;
        crc = 16'h4aba;
        n = 0;
        // an early stop still lets two words through
        while (pos < WORDS && !(stop_early_in && n == 2)) begin
          @(posedge clk_in);
          w = 16'($urandom);
          dd_out <= w;
          strobe_out <= 1'b1;
          crc = crc_step(crc, w);
          pos++;
          n++;
          @(posedge clk_in);
          strobe_out <= 1'b0;
        end
        for (int k = 0; k < 20 && pos == WORDS && dmarq_in; k++) @(negedge clk_in);
        @(posedge clk_in);
        stop_out <= 1'b1;
        for (int k = 0; k < 20 && dmarq_in; k++) @(negedge clk_in);
        @(posedge clk_in);
        dd_out <= crc ^ {16{bad_crc_in}};
        @(posedge clk_in);
        dmack_n_out <= 1'b1;
        @(posedge clk_in);
        stop_out <= 1'b0;
        dd_out <= ~crc;
        if (pos == WORDS) pos = 0;
      end else begin
        // released bus: keep it moving so no stale value looks valid
        dd_out <= ~dd_out;
      end
    end
  end
endmodule // atacpe_host_model
`default_nettype wire

// file: verification/atacpe_engine_properties.sv
// concurrent checks on the ports of the protocol engine
`timescale 1ns/100ps
`default_nettype none
module atacpe_engine_properties (
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  input wire logic SOFT_RESET_IN,
  input wire logic [2:0] ADDR_IN,
  input wire logic WRITE_IN,
  input wire logic READ_IN,
  input wire logic ALT_READ_IN,
  input wire logic PARAM_BAD_IN,
  input wire logic UNIT_READY_IN,
  input wire logic MEDIA_ERROR_IN,
  input wire logic DMACK_N_IN,
  input wire logic STOP_IN,
  input wire logic INTRQ_OUT,
  input wire logic DMARQ_OUT,
  input wire logic [7:0] STATUS_OUT,
  input wire logic UDMA_ON_OUT,
  input wire logic [2:0] DMA_MODE_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);
  wire logic sts = READ_IN && ADDR_IN == atacpe_pkg::ADDR_STATUS_COMMAND;
  wire logic cmw = WRITE_IN && ADDR_IN == atacpe_pkg::ADDR_STATUS_COMMAND;
  wire logic evt = UNIT_READY_IN || PARAM_BAD_IN || MEDIA_ERROR_IN;
  wire logic bsy = STATUS_OUT[atacpe_pkg::ST_BSY];
  wire logic idle = !bsy && !STATUS_OUT[atacpe_pkg::ST_DRQ];
  sequence s_host_stop;
    DMARQ_OUT && !DMACK_N_IN && STOP_IN;
  endsequence
  sequence s_req_gone;
    ##[1:3] !DMARQ_OUT;
  endsequence
  cmd_clears_irq_a: assert property (cmw && idle && !evt && !SOFT_RESET_IN |=> !INTRQ_OUT && bsy)
    else $error("command write left interrupt or no busy");
  status_read_clear_a: assert property (sts && !ALT_READ_IN && !evt |=> !INTRQ_OUT)
    else $error("status read did not clear interrupt");
  alt_read_keep_a: assert property (INTRQ_OUT && sts && ALT_READ_IN && !SOFT_RESET_IN |=> INTRQ_OUT)
    else $error("alternate status read cleared interrupt");
  irq_level_hold_a: assert property (INTRQ_OUT && !sts && !cmw && !SOFT_RESET_IN |=> INTRQ_OUT)
    else $error("interrupt dropped without clearing action");
  irq_busy_clear_a: assert property ($rose(INTRQ_OUT) |-> !bsy)
    else $error("interrupt raised while busy");
  dma_no_irq_a: assert property (DMARQ_OUT |-> !INTRQ_OUT)
    else $error("interrupt during dma transfer");
  abort_report_a: assert property (PARAM_BAD_IN && bsy && !SOFT_RESET_IN |-> ##[1:2] (INTRQ_OUT && STATUS_OUT == 8'h51))
    else $error("invalid parameter not reported");
  host_stop_ack_a: assert property (s_host_stop |-> s_req_gone)
    else $error("stop not acknowledged");
  mode_default_a: assert property ($fell(RESET_IN) |-> DMA_MODE_OUT == atacpe_pkg::RST_DMA_MODE && !UDMA_ON_OUT)
    else $error("dma mode not default after reset");
  busy_no_drq_a: assert property (bsy |-> !STATUS_OUT[atacpe_pkg::ST_DRQ])
    else $error("busy and data request together");
endmodule // atacpe_engine_properties
bind atacpe_engine atacpe_engine_properties i_props (.CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN),
  .SOFT_RESET_IN(SOFT_RESET_IN), .ADDR_IN(ADDR_IN), .WRITE_IN(WRITE_IN), .READ_IN(READ_IN),
  .ALT_READ_IN(ALT_READ_IN), .PARAM_BAD_IN(PARAM_BAD_IN), .UNIT_READY_IN(UNIT_READY_IN),
  .MEDIA_ERROR_IN(MEDIA_ERROR_IN), .DMACK_N_IN(DMACK_N_IN), .STOP_IN(STOP_IN), .INTRQ_OUT(INTRQ_OUT),
  .DMARQ_OUT(DMARQ_OUT), .STATUS_OUT(STATUS_OUT), .UDMA_ON_OUT(UDMA_ON_OUT), .DMA_MODE_OUT(DMA_MODE_OUT));
`default_nettype wire

// file: verification/test_ata_command_protocol_engine.sv
// self-checking bench for the ata command protocol engine
`timescale 1ns/100ps
`default_nettype none
module test_ata_command_protocol_engine;
  localparam int W = 4;
  logic clk = '0, rst = '1, srst = '0, wr = '0, rd = '0, alt = '0, dw = '0, mul = '0, bad = '0;
  logic rdy = '0, merr = '0, unc = '0, smul = '0, sx = '0, early = '0, bcrc = '0;
  logic [1:0] xk = '0;
  logic [2:0] a = '0, cls = '0, xm = '0, mode;
  logic [3:0] fh = '0;
  logic [7:0] wd = '0, fs = '0, r, rdata, status;
  logic [15:0] fc = '0, dd;
  logic dmack_n, stop, strobe, intrq, dmarq, udma, crce, cstb;
  logic [7:0] cmdo;
  int err_count = 0, cmp_count = 0;
  always #50 clk = ~clk;
  atacpe_engine #(.WORDS_PER_SECTOR(W)) i_dut (.CLOCK_IN(clk), .RESET_IN(rst), .SOFT_RESET_IN(srst),
    .ADDR_IN(a), .WDATA_IN(wd), .WRITE_IN(wr), .READ_IN(rd), .ALT_READ_IN(alt), .RDATA_OUT(rdata),
    .DATA_WORD_IN(dw), .CMD_CLASS_IN(cls), .CMD_MULTIPLE_IN(mul), .PARAM_BAD_IN(bad), .UNIT_READY_IN(rdy),
    .MEDIA_ERROR_IN(merr), .MEDIA_UNC_IN(unc), .FAIL_SECNUM_IN(fs), .FAIL_CYL_IN(fc), .FAIL_HEAD_IN(fh),
    .SET_MULTIPLE_IN(smul), .SET_XFER_IN(sx), .SET_XFER_KIND_IN(xk), .SET_XFER_MODE_IN(xm),
    .DMACK_N_IN(dmack_n), .STOP_IN(stop), .STROBE_WORD_IN(strobe), .DD_IN(dd), .DEV_END_BURST_IN(1'b0),
    .INTRQ_OUT(intrq), .DMARQ_OUT(dmarq), .STATUS_OUT(status), .COMMAND_OUT(cmdo), .COMMAND_STROBE_OUT(cstb),
    .UDMA_ON_OUT(udma), .DMA_MODE_OUT(mode), .CRC_ERROR_OUT(crce));
  atacpe_host_model #(.WORDS(W)) i_host (.clk_in(clk), .rst_in(rst), .dmarq_in(dmarq), .stop_early_in(early),
    .bad_crc_in(bcrc), .dmack_n_out(dmack_n), .stop_out(stop), .strobe_out(strobe), .dd_out(dd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic flag(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wreg(input logic [2:0] ad, input logic [7:0] d);
    @(posedge clk);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] ad, input logic al, output logic [7:0] d);
    @(posedge clk);
    a <= ad;
    alt <= al;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    alt <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // kinds: 0 ready, 1 data word, 2 bad parameter, 3 media error, 4 set multiple, 5 set transfer, 6 soft reset
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: rdy <= 1'b1;
      1: dw <= 1'b1;
      2: bad <= 1'b1;
      3: {rdy, merr} <= 2'h3;
      4: smul <= 1'b1;
      5: sx <= 1'b1;
      default: srst <= 1'b1;
    endcase
    @(posedge clk);
    {rdy, dw, bad, merr, smul, sx, srst} <= '0;
  endtask
  task automatic wirq(input int n);
    for (int i = 0; i < n && intrq !== 1'b1; i++) @(negedge clk);
  endtask
  task automatic ack(input logic [7:0] exp);
    rreg(3'h7, 1'b0, r);
    chk(r, exp);
    flag(intrq, 1'b0);
  endtask
  task automatic cmd(input logic [2:0] c, input logic m, input logic [7:0] cnt);
    logic [7:0] cc;
    cc = 8'($urandom);
    for (int i = 1; i < 7; i++) wreg(3'(i), i == 2 ? cnt : 8'($urandom));
    cls <= c;
    mul <= m;
    wreg(3'h7, cc);
    @(negedge clk);
    chk(status, 8'h80);
    chk(cmdo, cc);
    flag(cstb, 1'b1);
    flag(intrq, 1'b0);
  endtask
  task automatic words(input int n);
    repeat (n) pulse(1);
    @(negedge clk);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // each test takes well under a thousand cycles; allow a wide margin
  initial begin
    #(20000 * 100);
    err_count++;
    results();
  end
  initial begin
    void'($urandom(32'h508a_e9e7));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(status, 8'h50);
    chk({5'h00, mode}, 8'h02);
    $display("test reset done");
    cmd(3'h0, 1'b0, 8'h01);
    pulse(0);
    wirq(40);
    chk(status, 8'h50);
    rreg(3'h7, 1'b1, r);
    flag(intrq, 1'b1);
    ack(8'h50);
    $display("test nondata done");
    cmd(3'h1, 1'b0, 8'h02);
    repeat (2) begin
      pulse(0);
      wirq(40);
      ack(8'h58);
      words(W);
      flag(status[3], 1'b0);
    end
    wreg(3'h2, 8'h02);
    pulse(4);
    cmd(3'h1, 1'b1, 8'h02);
    pulse(0);
    wirq(40);
    ack(8'h58);
    words(W);
    flag(status[3], 1'b1);
    words(W);
    flag(status[3], 1'b0);
    $display("test pio in done");
    fs <= 8'($urandom);
    fc <= 16'($urandom);
    fh <= 4'($urandom);
    unc <= 1'b1;
    cmd(3'h1, 1'b0, 8'h01);
    pulse(3);
    wirq(40);
    ack(8'h59);
    rreg(3'h1, 1'b0, r);
    flag(r[6], 1'b1);
    rreg(3'h3, 1'b0, r);
    chk(r, fs);
    rreg(3'h4, 1'b0, r);
    chk(r, fc[7:0]);
    rreg(3'h5, 1'b0, r);
    chk(r, fc[15:8]);
    rreg(3'h6, 1'b0, r);
    chk({4'h0, r[3:0]}, {4'h0, fh});
    words(W);
    flag(status[3], 1'b0);
    unc <= 1'b0;
    $display("test read error done");
    cmd(3'h2, 1'b0, 8'h01);
    pulse(0);
    @(negedge clk);
    chk(status, 8'h58);
    flag(intrq, 1'b0);
    words(W);
    chk(status, 8'h80);
    pulse(0);
    wirq(40);
    ack(8'h50);
    cmd(3'h2, 1'b0, 8'h02);
    pulse(0);
    words(W);
    pulse(3);
    wirq(40);
    chk(status, 8'h59);
    pulse(6);
    @(negedge clk);
    chk(status, 8'h50);
    flag(intrq, 1'b0);
    $display("test pio out done");
    for (int c = 0; c < 5; c++) begin
      cmd(3'(c), 1'b0, 8'h01);
      pulse(2);
      wirq(40);
      rreg(3'h1, 1'b0, r);
      flag(r[2], 1'b1);
      ack(8'h51);
    end
    $display("test abort done");
    for (int u = 0; u < 2; u++) begin
      if (u == 1) begin
        xk <= 2'h1;
        xm <= 3'($urandom_range(0, 5));
        pulse(5);
        @(negedge clk);
        flag(udma, 1'b1);
        chk({5'h00, mode}, {5'h00, xm});
      end
      for (int c = 3; c < 5; c++) begin
        early <= c == 4;
        cmd(3'(c), 1'b0, 8'h02);
        pulse(0);
        wirq(400);
        ack(8'h50);
        flag(crce, 1'b0);
      end
    end
    bcrc <= 1'b1;
    cmd(3'h3, 1'b0, 8'h01);
    pulse(0);
    wirq(400);
    flag(crce, 1'b1);
    ack(8'h51);
    $display("test dma done");
    results();
  end
endmodule // test_ata_command_protocol_engine
`default_nettype wire
